/* hw/pwt_pkg.sv */
// package: register map, field layout and encodings of the pwm timebase block
package pwt_pkg;

    // ------------------------------------------------------------
    // register indices (byte address on apb is four times the index)
    // ------------------------------------------------------------
    localparam logic [11:0] IDX_CLOCK_SOURCE   = 12'h48D;
    localparam logic [11:0] IDX_LOAD_TRIGGER   = 12'h48E;
    localparam logic [11:0] IDX_PERIOD_LOW     = 12'h48F;
    localparam logic [11:0] IDX_PERIOD_HIGH    = 12'h490;
    localparam logic [11:0] IDX_PRESCALER      = 12'h491;
    localparam logic [11:0] IDX_POSTSCALER     = 12'h492;
    localparam logic [11:0] IDX_PARAM_FLAGS    = 12'h493;
    localparam logic [11:0] IDX_IRQ_STATUS     = 12'h4A0;
    localparam logic [11:0] IDX_IRQ_MASK       = 12'h4A1;
    localparam int          ADDR_LSB           = 2;

    // ------------------------------------------------------------
    // field widths and reset values
    // ------------------------------------------------------------
    localparam int          CLK_SEL_W          = 4;
    localparam int          LOAD_SEL_W         = 3;
    localparam int          NUM_SOURCES        = 16;
    localparam int          NUM_IRQ            = 3;
    localparam logic [7:0]  BYTE_RESET         = 8'h00;
    localparam logic [15:0] PERIOD_RESET       = 16'h0000;
    localparam logic [31:0] WORD_ZERO          = 32'h0000_0000;

    // ------------------------------------------------------------
    // clock source codes, one source input bit per code
    // ------------------------------------------------------------
    localparam logic [3:0]  CLK_SEL_PIN0       = 4'h0;
    localparam logic [3:0]  CLK_SEL_SYSTEM     = 4'h2;
    localparam logic [3:0]  CLK_SEL_RESERVED   = 4'hF;

    // ------------------------------------------------------------
    // load trigger codes
    // ------------------------------------------------------------
    localparam logic [2:0]  LOAD_SEL_OFF       = 3'h0;
    localparam logic [2:0]  LOAD_SEL_PIN0      = 3'h1;
    localparam logic [2:0]  LOAD_SEL_PIN1      = 3'h2;
    localparam logic [2:0]  LOAD_SEL_CELL1     = 3'h3;
    localparam logic [2:0]  LOAD_SEL_CELL4     = 3'h6;
    localparam logic [2:0]  LOAD_SEL_RESERVED  = 3'h7;

    // ------------------------------------------------------------
    // slice modes and flag / status bit positions
    // ------------------------------------------------------------
    localparam logic [2:0]  MODE_LEFT          = 3'h0;
    localparam logic [2:0]  MODE_RIGHT         = 3'h1;
    localparam logic [2:0]  MODE_CENTER        = 3'h2;
    localparam logic [2:0]  MODE_VARIABLE      = 3'h3;
    localparam logic [2:0]  MODE_CMP_SET       = 3'h4;
    localparam logic [2:0]  MODE_CMP_TOGGLE    = 3'h5;
    localparam int          FLAG_P1            = 0;
    localparam int          FLAG_P2            = 1;
    localparam int          IRQ_PERIOD         = 0;
    localparam int          IRQ_P1             = 1;
    localparam int          IRQ_P2             = 2;

endpackage : pwt_pkg

/* hw/pwt_sync.sv */
// two-stage synchroniser bank for inputs from outside the clock domain
`timescale 1ns/100ps
module pwt_sync #(
    parameter int W = 1
) (
    input  wire logic         clock,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    // ------------------------------------------------------------
    // per-bit flop pair; first stage feeds only the second
    // ------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_r;
            logic meta_nxt;
            logic q_nxt;
            // next values simply follow the chain
            always_comb begin
                meta_nxt = d[i];
                q_nxt    = meta_r;
            end
            always_ff @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    meta_r <= 1'b0;
                    q[i]   <= 1'b0;
                end else begin
                    meta_r <= meta_nxt;
                    q[i]   <= q_nxt;
                end
            end
        end
    endgenerate
endmodule : pwt_sync

/* hw/pwt_timebase.sv */
// pwm timebase: clock select, prescaler, period timer, load trigger, postscaler, flags, apb
// ------------------------------------------------------------
// Functional notes
// - A 4-bit field picks the timer clock among logic cells, oscillators, system clock and two pins.
// - A 3-bit field picks the auto-load trigger: 0 off, 1-2 pins, 3-6 logic cells, 7 reserved.
// - A 16-bit period value sets how many prescaled ticks make one pwm period.
// - The period value is reached as a low byte and a high byte at separate addresses.
// - The selected clock is divided by the prescale value plus one.
// - The period interrupt fires once every postscale value plus one period events.
// - In variable or compare mode a parameter flag sets when the counter matches its parameter.
// - In right mode a flag sets on the rising output edge, in center mode on any output change.
// - In left mode a flag sets on the falling output edge.
// - Flags are set by hardware, read zero until an event, and software clears them by writing zero.
// - A period event happens when the timer equals the period, and the timer resets then.
// - In sleep the block only runs if the selected clock keeps running in sleep.
// - The postscale counter resets while disabled, and postscale changes act at once.
// ------------------------------------------------------------
`timescale 1ns/100ps
module pwt_timebase (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [15:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pin_input_zero,
    input  wire logic        pin_input_one,
    input  wire logic        logic_cell_one_out,
    input  wire logic        logic_cell_two_out,
    input  wire logic        logic_cell_three_out,
    input  wire logic        logic_cell_four_out,
    input  wire logic        numeric_oscillator_out,
    input  wire logic        reference_clock_out,
    input  wire logic        ext_osc_in,
    input  wire logic        sec_osc_in,
    input  wire logic        mf32_osc_in,
    input  wire logic        mf500_osc_in,
    input  wire logic        lf_osc_in,
    input  wire logic        hf_osc_in,
    input  wire logic        sleep_mode,
    input  wire logic        pwm_enable,
    input  wire logic        load_request,
    input  wire logic [2:0]  slice_mode,
    input  wire logic        param_one_match,
    input  wire logic        param_two_match,
    input  wire logic        param_one_out,
    input  wire logic        param_two_out,
    output logic [15:0]      timer_value,
    output logic [15:0]      period_active,
    output logic             period_event,
    output logic             period_irq,
    output logic             load_done,
    output logic             irq
);
    // ------------------------------------------------------------
    // source synchronisers; bit n is the source of clock code n
    // ------------------------------------------------------------
    logic [pwt_pkg::NUM_SOURCES-1:0] src_raw;
    logic [pwt_pkg::NUM_SOURCES-1:0] src_sync;
    logic [pwt_pkg::NUM_SOURCES-1:0] src_prev_r;
    assign src_raw = {1'b0, logic_cell_four_out, logic_cell_three_out, logic_cell_two_out,
                      logic_cell_one_out, numeric_oscillator_out, reference_clock_out,
                      ext_osc_in, sec_osc_in, mf32_osc_in, mf500_osc_in, lf_osc_in,
                      hf_osc_in, 1'b1, pin_input_one, pin_input_zero};
    pwt_sync #(.W(pwt_pkg::NUM_SOURCES)) u_sync (
        .clock (clock),
        .rst_b (rst_b),
        .d     (src_raw),
        .q     (src_sync)
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [3:0]  clk_sel_r,   clk_sel_nxt;
    logic [2:0]  load_sel_r,  load_sel_nxt;
    logic [15:0] period_r,    period_nxt;
    logic [7:0]  prescale_r,  prescale_nxt;
    logic [7:0]  postscale_r, postscale_nxt;
    logic [1:0]  flags_r,     flags_nxt;
    logic [2:0]  irq_st_r,    irq_st_nxt;
    logic [2:0]  irq_mask_r,  irq_mask_nxt;
    logic [31:0] prdata_nxt;
    logic [11:0] idx;
    logic        wr_en, rd_setup, mapped;
    logic [7:0]  wbyte;

    // ------------------------------------------------------------
    // timebase state
    // ------------------------------------------------------------
    logic [7:0]  pre_cnt_r,  pre_cnt_nxt;
    logic [15:0] timer_r,    timer_nxt;
    logic [15:0] per_buf_r,  per_buf_nxt;
    logic [7:0]  post_cnt_r, post_cnt_nxt;
    logic        load_pend_r, load_pend_nxt;
    logic        p1_prev_r, p2_prev_r;
    logic        per_evt_r, per_irq_r, load_done_r;
    logic        src_edge, tick, per_hit, post_hit, trig_edge, load_now;
    logic [1:0]  flag_set;
    // apb decode: zero wait states, read data latched in setup phase
    assign idx      = paddr[pwt_pkg::ADDR_LSB +: 12];
    assign wr_en    = psel & penable & pwrite & mapped;
    assign rd_setup = psel & ~penable & ~pwrite;
    assign wbyte    = pwdata[7:0];
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~mapped;
    always_comb begin
        case (idx)
            pwt_pkg::IDX_CLOCK_SOURCE, pwt_pkg::IDX_LOAD_TRIGGER, pwt_pkg::IDX_PERIOD_LOW,
            pwt_pkg::IDX_PERIOD_HIGH, pwt_pkg::IDX_PRESCALER, pwt_pkg::IDX_POSTSCALER,
            pwt_pkg::IDX_PARAM_FLAGS, pwt_pkg::IDX_IRQ_STATUS, pwt_pkg::IDX_IRQ_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end
    // read mux; unused upper bits read zero
    always_comb begin
        prdata_nxt = prdata;
        if (rd_setup) begin
            prdata_nxt = pwt_pkg::WORD_ZERO;
            case (idx)
                pwt_pkg::IDX_CLOCK_SOURCE: prdata_nxt[3:0] = clk_sel_r;
                pwt_pkg::IDX_LOAD_TRIGGER: prdata_nxt[2:0] = load_sel_r;
                pwt_pkg::IDX_PERIOD_LOW:   prdata_nxt[7:0] = period_r[7:0];
                pwt_pkg::IDX_PERIOD_HIGH:  prdata_nxt[7:0] = period_r[15:8];
                pwt_pkg::IDX_PRESCALER:    prdata_nxt[7:0] = prescale_r;
                pwt_pkg::IDX_POSTSCALER:   prdata_nxt[7:0] = postscale_r;
                pwt_pkg::IDX_PARAM_FLAGS:  prdata_nxt[1:0] = flags_r;
                pwt_pkg::IDX_IRQ_STATUS:   prdata_nxt[2:0] = irq_st_r;
                pwt_pkg::IDX_IRQ_MASK:     prdata_nxt[2:0] = irq_mask_r;
                default:                   prdata_nxt = pwt_pkg::WORD_ZERO;
            endcase
        end
    end
    // register writes; hardware set wins over a clearing write in the same cycle
    always_comb begin
        clk_sel_nxt   = clk_sel_r;
        load_sel_nxt  = load_sel_r;
        period_nxt    = period_r;
        prescale_nxt  = prescale_r;
        postscale_nxt = postscale_r;
        flags_nxt     = flags_r;
        irq_st_nxt    = irq_st_r;
        irq_mask_nxt  = irq_mask_r;
        if (wr_en) begin
            case (idx)
                pwt_pkg::IDX_CLOCK_SOURCE: clk_sel_nxt = wbyte[3:0];
                pwt_pkg::IDX_LOAD_TRIGGER: load_sel_nxt = wbyte[2:0];
                pwt_pkg::IDX_PERIOD_LOW:   period_nxt[7:0] = wbyte;
                pwt_pkg::IDX_PERIOD_HIGH:  period_nxt[15:8] = wbyte;
                pwt_pkg::IDX_PRESCALER:    prescale_nxt = wbyte;
                pwt_pkg::IDX_POSTSCALER:   postscale_nxt = wbyte;
                pwt_pkg::IDX_PARAM_FLAGS:  flags_nxt = wbyte[1:0];
                pwt_pkg::IDX_IRQ_STATUS:   irq_st_nxt = irq_st_r & ~wbyte[2:0];
                pwt_pkg::IDX_IRQ_MASK:     irq_mask_nxt = wbyte[2:0];
                default:                   flags_nxt = flags_r;
            endcase
        end
        flags_nxt  = flags_nxt | flag_set;
        irq_st_nxt = irq_st_nxt | {flag_set, post_hit};
    end

    // ------------------------------------------------------------
    // clock selection and prescaler
    // ------------------------------------------------------------
    // system clock stops in sleep, so it yields no ticks then
    always_comb begin
        src_edge = src_sync[clk_sel_r] & ~src_prev_r[clk_sel_r];
        if (clk_sel_r == pwt_pkg::CLK_SEL_SYSTEM)
            src_edge = ~sleep_mode;
        else if (clk_sel_r == pwt_pkg::CLK_SEL_RESERVED)
            src_edge = 1'b0;
        tick = pwm_enable & src_edge & (pre_cnt_r == prescale_r);
        if (!pwm_enable)
            pre_cnt_nxt = pwt_pkg::BYTE_RESET;
        else if (src_edge)
            pre_cnt_nxt = tick ? pwt_pkg::BYTE_RESET : pre_cnt_r + 8'h01;
        else
            pre_cnt_nxt = pre_cnt_r;
    end

    // ------------------------------------------------------------
    // load trigger select and buffered period timer
    // ------------------------------------------------------------
    always_comb begin
        case (load_sel_r)
            pwt_pkg::LOAD_SEL_PIN0:  trig_edge = src_sync[0] & ~src_prev_r[0];
            pwt_pkg::LOAD_SEL_PIN1:  trig_edge = src_sync[1] & ~src_prev_r[1];
            3'h3, 3'h4, 3'h5, pwt_pkg::LOAD_SEL_CELL4: begin
                trig_edge = src_sync[load_sel_r + 4'h8] & ~src_prev_r[load_sel_r + 4'h8];
            end
            default:                 trig_edge = 1'b0;                         // off and reserved
        endcase
        per_hit       = tick & (timer_r == per_buf_r);
        load_now      = per_hit & load_pend_r;
        load_pend_nxt = pwm_enable & ((load_pend_r & ~per_hit) | load_request | trig_edge);
        if (!pwm_enable) begin
            timer_nxt   = pwt_pkg::PERIOD_RESET;
            per_buf_nxt = period_r;                                              // copied on enable
        end else begin
            timer_nxt   = per_hit ? pwt_pkg::PERIOD_RESET : timer_r + (tick ? 16'h0001 : 16'h0000);
            per_buf_nxt = load_now ? period_r : per_buf_r;
        end
    end

    // ------------------------------------------------------------
    // period interrupt postscaler; live compare so changes act at once
    // ------------------------------------------------------------
    always_comb begin
        post_hit = per_hit & (post_cnt_r >= postscale_r);
        if (!pwm_enable)
            post_cnt_nxt = pwt_pkg::BYTE_RESET;
        else if (per_hit)
            post_cnt_nxt = post_hit ? pwt_pkg::BYTE_RESET : post_cnt_r + 8'h01;
        else
            post_cnt_nxt = post_cnt_r;
    end

    // ------------------------------------------------------------
    // parameter flag events per slice mode
    // ------------------------------------------------------------
    always_comb begin
        case (slice_mode)
            pwt_pkg::MODE_VARIABLE, pwt_pkg::MODE_CMP_SET, pwt_pkg::MODE_CMP_TOGGLE:
                flag_set = {param_two_match, param_one_match};
            pwt_pkg::MODE_RIGHT:
                flag_set = {param_two_out & ~p2_prev_r, param_one_out & ~p1_prev_r};
            pwt_pkg::MODE_CENTER:
                flag_set = {param_two_out ^ p2_prev_r, param_one_out ^ p1_prev_r};
            pwt_pkg::MODE_LEFT:
                flag_set = {~param_two_out & p2_prev_r, ~param_one_out & p1_prev_r};
            default:
                flag_set = 2'b00;
        endcase
    end

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            clk_sel_r   <= '0;
            load_sel_r  <= '0;
            period_r    <= pwt_pkg::PERIOD_RESET;
            prescale_r  <= pwt_pkg::BYTE_RESET;
            postscale_r <= pwt_pkg::BYTE_RESET;
            flags_r     <= '0;
            irq_st_r    <= '0;
            irq_mask_r  <= '0;
            prdata      <= pwt_pkg::WORD_ZERO;
            src_prev_r  <= '0;
            pre_cnt_r   <= pwt_pkg::BYTE_RESET;
            timer_r     <= pwt_pkg::PERIOD_RESET;
            per_buf_r   <= pwt_pkg::PERIOD_RESET;
            post_cnt_r  <= pwt_pkg::BYTE_RESET;
            load_pend_r <= 1'b0;
            p1_prev_r   <= 1'b0;
            p2_prev_r   <= 1'b0;
            per_evt_r   <= 1'b0;
            per_irq_r   <= 1'b0;
            load_done_r <= 1'b0;
        end else begin
            clk_sel_r   <= clk_sel_nxt;
            load_sel_r  <= load_sel_nxt;
            period_r    <= period_nxt;
            prescale_r  <= prescale_nxt;
            postscale_r <= postscale_nxt;
            flags_r     <= flags_nxt;
            irq_st_r    <= irq_st_nxt;
            irq_mask_r  <= irq_mask_nxt;
            prdata      <= prdata_nxt;
            src_prev_r  <= src_sync;
            pre_cnt_r   <= pre_cnt_nxt;
            timer_r     <= timer_nxt;
            per_buf_r   <= per_buf_nxt;
            post_cnt_r  <= post_cnt_nxt;
            load_pend_r <= load_pend_nxt;
            p1_prev_r   <= param_one_out;
            p2_prev_r   <= param_two_out;
            per_evt_r   <= per_hit;
            per_irq_r   <= post_hit;
            load_done_r <= load_now;
        end
    end
    assign timer_value   = timer_r;
    assign period_active = per_buf_r;
    assign period_event  = per_evt_r;
    assign period_irq    = per_irq_r;
    assign load_done     = load_done_r;
    assign irq           = |(irq_st_r & irq_mask_r);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_period_hit;
        tick && (timer_r == per_buf_r);
    endsequence
    reserved_clock_a: assert property (clk_sel_r == pwt_pkg::CLK_SEL_RESERVED |-> !tick)
        else $error("tick from reserved clock source");
    load_off_a: assert property ((load_sel_r == pwt_pkg::LOAD_SEL_OFF && !load_request && !load_pend_r
        && pwm_enable) |=> !load_pend_r)
        else $error("load pending with trigger disabled");
    timer_range_a: assert property (pwm_enable && $past(pwm_enable) && !$past(load_now)
        |-> timer_r <= per_buf_r)
        else $error("timer ran past the period");
    period_byte_a: assert property (wr_en && idx == pwt_pkg::IDX_PERIOD_HIGH
        |=> period_r[15:8] == $past(wbyte) && period_r[7:0] == $past(period_r[7:0]))
        else $error("period high byte write disturbed");
    prescale_div_a: assert property (tick && prescale_r == 8'h01 && clk_sel_r == pwt_pkg::CLK_SEL_SYSTEM
        && !sleep_mode && $stable(prescale_r) ##1 (pwm_enable && !sleep_mode && $stable(prescale_r))
        |-> !tick)
        else $error("prescaler ticked early");
    postscale_a: assert property (post_hit |-> per_hit && post_cnt_r >= postscale_r
        ##1 per_irq_r && post_cnt_r == pwt_pkg::BYTE_RESET)
        else $error("postscaled interrupt out of step");
    compare_flag_a: assert property (slice_mode == pwt_pkg::MODE_VARIABLE && param_one_match
        |=> flags_r[pwt_pkg::FLAG_P1])
        else $error("match did not set flag one");
    right_edge_a: assert property (slice_mode == pwt_pkg::MODE_RIGHT && $rose(param_two_out)
        |=> flags_r[pwt_pkg::FLAG_P2])
        else $error("rising edge did not set flag two");
    left_edge_a: assert property (slice_mode == pwt_pkg::MODE_LEFT && $fell(param_one_out)
        |=> flags_r[pwt_pkg::FLAG_P1])
        else $error("falling edge did not set flag one");
    flag_clear_a: assert property (wr_en && idx == pwt_pkg::IDX_PARAM_FLAGS && !wbyte[0] && !flag_set[0]
        |=> !flags_r[pwt_pkg::FLAG_P1])
        else $error("writing zero did not clear flag one");
    period_reset_a: assert property (s_period_hit |=> timer_r == pwt_pkg::PERIOD_RESET && per_evt_r)
        else $error("period match did not reset the timer");
    sleep_stop_a: assert property (sleep_mode && clk_sel_r == pwt_pkg::CLK_SEL_SYSTEM |-> !tick)
        else $error("system clock ticked in sleep");
    disable_clear_a: assert property (!pwm_enable |=> post_cnt_r == pwt_pkg::BYTE_RESET
        && pre_cnt_r == pwt_pkg::BYTE_RESET)
        else $error("counters not cleared while disabled");
endmodule : pwt_timebase

/* tb/pwm_timebase_and_irq_flags_tb.sv */
// testbench of the pwm timebase block: registers, timing, flags and interrupt
`timescale 1ns/100ps
module pwm_timebase_and_irq_flags_tb;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr, err;
    logic [15:0] paddr, timer_value, period_active;
    logic [31:0] pwdata, prdata, rd;
    logic        period_event, period_irq, load_done, irq, en, ldr, m1, m2, o1, o2, slp;
    logic [2:0]  mode;
    logic [13:0] src;
    int          num_errors = 0, tests_run = 0, n;
    logic [11:0] ridx [7] = '{pwt_pkg::IDX_CLOCK_SOURCE, pwt_pkg::IDX_LOAD_TRIGGER, pwt_pkg::IDX_PERIOD_LOW,
        pwt_pkg::IDX_PERIOD_HIGH, pwt_pkg::IDX_PRESCALER, pwt_pkg::IDX_POSTSCALER, pwt_pkg::IDX_IRQ_MASK};
    logic [7:0]  rexp [7] = '{8'h0F, 8'h07, 8'hA5, 8'h5A, 8'h3C, 8'hC3, 8'h07};
    pwt_timebase i_dut (.clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_input_zero(src[0]), .pin_input_one(src[1]), .logic_cell_one_out(src[2]),
        .logic_cell_two_out(src[3]), .logic_cell_three_out(src[4]), .logic_cell_four_out(src[5]),
        .numeric_oscillator_out(src[6]), .reference_clock_out(src[7]), .ext_osc_in(src[8]),
        .sec_osc_in(src[9]), .mf32_osc_in(src[10]), .mf500_osc_in(src[11]), .lf_osc_in(src[12]),
        .hf_osc_in(src[13]), .sleep_mode(slp), .pwm_enable(en), .load_request(ldr), .slice_mode(mode),
        .param_one_match(m1), .param_two_match(m2), .param_one_out(o1), .param_two_out(o2),
        .timer_value(timer_value), .period_active(period_active), .period_event(period_event),
        .period_irq(period_irq), .load_done(load_done), .irq(irq));
    // --------------------------------------------------------
    // clock, shared tasks and watchdog
    // --------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    // one apb transfer; an idle edge follows so that psel is never assigned twice in one step
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
        psel <= 1'b1; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd; penable <= 1'b0;
        @(posedge clock);
        penable <= 1'b1;
        // no wait-state count is assumed; only the watchdog ends a hung transfer
        do begin @(posedge clock); end while (pready !== 1'b1);
        rd = prdata; err = pslverr; psel <= 1'b0; penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    // cycles from one pulse of the chosen output to the next
    task automatic gap(input bit sel, output int cnt);
        cnt = 0;
        while ((sel ? period_irq : period_event) !== 1'b1 && cnt < 999) begin @(posedge clock); cnt++; end
        cnt = 0;
        do begin @(posedge clock); cnt++; end while ((sel ? period_irq : period_event) !== 1'b1 && cnt < 999);
    endtask : gap
    task automatic report_and_stop;
        if (num_errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        #100000;
        num_errors++;
        report_and_stop;
    end
    // --------------------------------------------------------
    // main sequence
    // --------------------------------------------------------
    initial begin
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000; pwdata = 32'h0;
        src = 14'h0000; slp = 1'b0; en = 1'b0; ldr = 1'b0; mode = 3'h3; {m1, m2, o1, o2} = 4'h0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        // reset value, then write all ones (clock source, load trigger, irq mask) or the expected pattern and read the field back
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ridx[i], 32'h0); chk("reset", rd, 32'h0);
            apb(1'b1, ridx[i], {24'h0, rexp[i] | ((i < 2 || i == 6) ? 8'hFF : 8'h00)});
            apb(1'b0, ridx[i], 32'h0); chk("field", rd, {24'h0, rexp[i]});
        end
        apb(1'b0, 12'h000, 32'h0); chk("unmapped", {31'h0, err}, 32'h1);
        // system clock, prescale 1, period 2, postscale 2
        apb(1'b1, pwt_pkg::IDX_CLOCK_SOURCE, 32'h2); apb(1'b1, pwt_pkg::IDX_PERIOD_LOW, 32'h2);
        apb(1'b1, pwt_pkg::IDX_PERIOD_HIGH, 32'h0); apb(1'b1, pwt_pkg::IDX_PRESCALER, 32'h1);
        apb(1'b1, pwt_pkg::IDX_POSTSCALER, 32'h2); apb(1'b1, pwt_pkg::IDX_IRQ_MASK, 32'h2);
        en <= 1'b1;
        gap(1'b0, n); gap(1'b0, n); chk("event gap", n, 32'd6);
        gap(1'b1, n); gap(1'b1, n); chk("irq gap", n, 32'd18);
        // compare match in variable mode sets flag one and raises the unmasked interrupt
        m1 <= 1'b1; @(posedge clock); m1 <= 1'b0; repeat (2) @(posedge clock);
        apb(1'b0, pwt_pkg::IDX_PARAM_FLAGS, 32'h0); chk("flag p1", rd, 32'h1);
        chk("irq set", {31'h0, irq}, 32'h1);
        apb(1'b1, pwt_pkg::IDX_PARAM_FLAGS, 32'h0); apb(1'b0, pwt_pkg::IDX_PARAM_FLAGS, 32'h0);
        chk("flag clr", rd, 32'h0);
        apb(1'b1, pwt_pkg::IDX_IRQ_STATUS, 32'h2); chk("irq clr", {31'h0, irq}, 32'h0);
        // left mode: a rising output edge must not set the flag, the falling one must
        mode <= pwt_pkg::MODE_LEFT; o2 <= 1'b1; repeat (2) @(posedge clock);
        apb(1'b0, pwt_pkg::IDX_PARAM_FLAGS, 32'h0); chk("left rise", rd, 32'h0);
        o2 <= 1'b0; repeat (2) @(posedge clock);
        apb(1'b0, pwt_pkg::IDX_PARAM_FLAGS, 32'h0); chk("left fall", rd, 32'h2);
        // center mode sets on any change, right mode only on the rising edge
        mode <= pwt_pkg::MODE_CENTER; o1 <= 1'b1; repeat (2) @(posedge clock);
        apb(1'b0, pwt_pkg::IDX_PARAM_FLAGS, 32'h0); chk("center", rd, 32'h3);
        apb(1'b1, pwt_pkg::IDX_PARAM_FLAGS, 32'h0); mode <= pwt_pkg::MODE_RIGHT; o1 <= 1'b0; o2 <= 1'b1;
        repeat (2) @(posedge clock);
        apb(1'b0, pwt_pkg::IDX_PARAM_FLAGS, 32'h0); chk("right", rd, 32'h2);
        // a new period stays buffered until a request, then a pin trigger, meets a period event
        apb(1'b1, pwt_pkg::IDX_PERIOD_LOW, 32'h4); chk("buffered", {16'h0, period_active}, 32'h2);
        ldr <= 1'b1; @(posedge clock); ldr <= 1'b0;
        n = 0; while (load_done !== 1'b1 && n < 99) begin @(posedge clock); n++; end
        chk("load req", {15'h0, load_done, period_active}, 32'h1_0004);
        gap(1'b0, n); chk("new gap", n, 32'd10);
        apb(1'b1, pwt_pkg::IDX_LOAD_TRIGGER, 32'h1); apb(1'b1, pwt_pkg::IDX_PERIOD_LOW, 32'h2); src[0] <= 1'b1;
        n = 0; while (load_done !== 1'b1 && n < 99) begin @(posedge clock); n++; end
        chk("load pin", {15'h0, load_done, period_active}, 32'h1_0002);
        // disable clears the timer; a sleeping system clock keeps it from starting again
        slp <= 1'b1; en <= 1'b0; repeat (2) @(posedge clock);
        chk("disabled", {16'h0, timer_value}, 32'h0);
        en <= 1'b1; repeat (4) @(posedge clock);
        chk("sleep", {16'h0, timer_value}, 32'h0);
        // reset in mid-run drops the pending interrupt and clears the registers
        rst_b <= 1'b0; @(posedge clock); rst_b <= 1'b1; @(posedge clock);
        chk("reset irq", {31'h0, irq}, 32'h0);
        apb(1'b0, pwt_pkg::IDX_PERIOD_LOW, 32'h0); chk("reset period", rd, 32'h0);
        report_and_stop;
    end
endmodule : pwm_timebase_and_irq_flags_tb
